// file: hw/remote_upgrade_sequencer_watchdog.sv
// Remote upgrade sequencer with control, status and user watchdog.
`timescale 1ns/1ns
module remote_upgrade_sequencer_watchdog #(
    parameter int CFG_CYC = upgrade_pkg::CFG_CYC_DEF
) (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire logic                           upgrade_user_clock,
    input  wire logic [1:0]                     addr,
    input  wire logic [upgrade_pkg::CTRL_W-1:0] wdata,
    input  wire logic                           wr_en,
    input  wire logic                           rd_en,
    output logic      [upgrade_pkg::CTRL_W-1:0] rdata,
    input  wire logic                           fabric_reconfig_request_n,
    input  wire logic                           watchdog_reload_n,
    input  wire logic                           config_error_pin_n,
    input  wire logic                           crc_error,
    input  wire logic                           ext_config_reset_n,
    output logic                                app_mode,
    output logic      [upgrade_pkg::PAGE_W-1:0] image_page_address,
    output logic                                reconfig_start,
    output logic                                watchdog_timeout
);
    import upgrade_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic [STAT_W-1:0] status_reg;
    logic [STAT_W-1:0] status_next;
    logic [WD_W-1:0]   wd_reg;
    logic [WD_W-1:0]   wd_next;
    logic [7:0]        cfg_cnt_reg;
    seq_state_t        state_reg;
    seq_state_t        state_next;
    logic [CTRL_W-1:0] stage_q;
    logic              req_pulse;
    logic              reload_pulse;
    logic              pin_err_reg;

    // Factory mode is a cleared application flag in the live register.
    wire factory_mode = !ctrl_reg[APP_BIT];
    wire wd_enabled   = ctrl_reg[APP_BIT] && ctrl_reg[WDEN_BIT];
    wire wd_running   = wd_enabled && (state_reg == SEQ_USER);
    wire wd_expired   = wd_running && (wd_reg == '0);
    wire stage_write  = wr_en && (addr == ADDR_STAGE);
    wire err_event    = crc_error || pin_err_reg || !ext_config_reset_n;
    wire fabric_go    = req_pulse && factory_mode;
    wire any_trigger  = err_event || wd_expired || fabric_go;
    wire cfg_done     = (cfg_cnt_reg == 8'(CFG_CYC - 1));

    // Timeout reload value: upper 12 bits from the setting, zeros below.
    function automatic logic [WD_W-1:0] load_value(
        input logic [CTRL_W-1:0] c
    );
        load_value = {c[TMO_LSB +: TMO_W], {WD_LOW_W{1'b0}}};
    endfunction : load_value

    // The staging register lives on the user clock.
    staging_reg #(
        .W(CTRL_W)
    ) u_stage (
        .upgrade_user_clock(upgrade_user_clock),
        .reset_n           (reset_n),
        .write_allow       (factory_mode),
        .write_en          (stage_write),
        .write_data        (wdata),
        .stage_q           (stage_q)
    );

    // The request must stand for the minimum hold before it is honoured.
    hold_filter #(
        .HOLD(HOLD_CYC)
    ) u_req (
        .clk         (clk),
        .reset_n     (reset_n),
        .level_in    (fabric_reconfig_request_n),
        .accept_pulse(req_pulse)
    );

    // Reload is active low and also needs the minimum hold.
    hold_filter #(
        .HOLD(HOLD_CYC)
    ) u_reload (
        .clk         (clk),
        .reset_n     (reset_n),
        .level_in    (!watchdog_reload_n),
        .accept_pulse(reload_pulse)
    );

    // Live control register update: only the sequencer writes it.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (err_event || wd_expired) begin
            ctrl_next = CTRL_RESET;
        end else if (fabric_go) begin
            ctrl_next = stage_q;
        end
    end

    // Cause recording; new causes win over nothing clearing them here.
    always_comb begin
        status_next = status_reg;
        if (any_trigger) begin
            status_next = '0;
            status_next[ST_CRC]    = crc_error;
            status_next[ST_ERRPIN] = pin_err_reg;
            status_next[ST_EXTRST] = !ext_config_reset_n;
            status_next[ST_WD]     = wd_expired;
            status_next[ST_FABRIC] = fabric_go && !err_event && !wd_expired;
        end
    end

    // Sequencer: configuration cycle, then user mode.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_CONFIG: begin
                if (cfg_done) begin
                    state_next = SEQ_RELOAD;
                end
            end
            SEQ_RELOAD: begin
                state_next = SEQ_USER;
            end
            SEQ_USER: begin
                state_next = SEQ_USER;
            end
            default: begin
                state_next = SEQ_CONFIG;
            end
        endcase
        if (any_trigger) begin
            state_next = SEQ_CONFIG;
        end
    end

    // Watchdog down-counter on the oscillator clock.
    always_comb begin
        wd_next = wd_reg;
        if (state_reg == SEQ_RELOAD || !wd_running) begin
            wd_next = load_value(ctrl_reg);
        end else if (reload_pulse) begin
            wd_next = load_value(ctrl_reg);
        end else if (wd_reg != '0) begin
            wd_next = wd_reg - WD_W'(1);
        end
    end

    // Read data selection for the register port.
    wire [CTRL_W-1:0] view_data = factory_mode ? stage_q : ctrl_reg;
    wire [CTRL_W-1:0] rd_mux =
        (addr == ADDR_STATUS) ? {{(CTRL_W-STAT_W){1'b0}}, status_reg} :
        (addr == ADDR_WDCNT)  ? {{(CTRL_W-WD_W){1'b0}}, wd_reg} :
        (addr == ADDR_READ || addr == ADDR_STAGE) ? view_data :
        '0;

    // Live control register on the oscillator clock.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Cause register, written in the same edge as the fallback.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= STAT_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Watchdog count, cleared so that a reset never looks like a load.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_reg <= '0;
        end else begin
            wd_reg <= wd_next;
        end
    end

    // Sequencer state, starting in a configuration cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SEQ_CONFIG;
        end else begin
            state_reg <= state_next;
        end
    end

    // Configuration cycle length counter.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_cnt_reg <= 8'h00;
        end else if (state_reg != SEQ_CONFIG || any_trigger) begin
            cfg_cnt_reg <= 8'h00;
        end else if (!cfg_done) begin
            cfg_cnt_reg <= cfg_cnt_reg + 8'h01;
        end
    end

    // The error pin is registered once, so its fallback lags a cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_err_reg <= 1'b0;
        end else begin
            pin_err_reg <= !config_error_pin_n;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= '0;
        end else begin
            rdata <= rd_en ? rd_mux : '0;
        end
    end

    // The application flag output mirrors the live register.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            app_mode <= 1'b0;
        end else begin
            app_mode <= ctrl_next[APP_BIT];
        end
    end

    // The page output mirrors the live register.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            image_page_address <= '0;
        end else begin
            image_page_address <= ctrl_next[PAGE_LSB +: PAGE_W];
        end
    end

    // One pulse for every trigger that the sequencer takes.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reconfig_start <= 1'b0;
        end else begin
            reconfig_start <= any_trigger;
        end
    end

    // One pulse when the watchdog runs out.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_timeout <= 1'b0;
        end else begin
            watchdog_timeout <= wd_expired;
        end
    end
endmodule : remote_upgrade_sequencer_watchdog

// file: hw/upgrade_pkg.sv
// Constants, types and field layout for the remote upgrade sequencer.
package upgrade_pkg;
    localparam int CTRL_W      = 38;
    localparam int PAGE_W      = 24;
    localparam int TMO_W       = 12;
    localparam int WD_W        = 29;
    localparam int WD_LOW_W    = WD_W - TMO_W;
    localparam int STAT_W      = 5;
    localparam int APP_BIT     = 0;
    localparam int PAGE_LSB    = 1;
    localparam int WDEN_BIT    = 25;
    localparam int TMO_LSB     = 26;
    localparam int ST_CRC      = 0;
    localparam int ST_ERRPIN   = 1;
    localparam int ST_FABRIC   = 2;
    localparam int ST_EXTRST   = 3;
    localparam int ST_WD       = 4;
    localparam int CLK_HZ      = 10_000_000;
    localparam int CLK_NS      = 1_000_000_000 / CLK_HZ;
    localparam int HOLD_NS     = 250;
    localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CFG_CYC_DEF = 16;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 38'h00_0000_0000;
    localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
    localparam logic [1:0] ADDR_STAGE  = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_READ   = 2'h2;
    localparam logic [1:0] ADDR_WDCNT  = 2'h3;

    typedef enum logic [1:0] {
        SEQ_CONFIG = 2'b00,
        SEQ_USER   = 2'b01,
        SEQ_RELOAD = 2'b10
    } seq_state_t;
endpackage : upgrade_pkg

// file: hw/hold_filter.sv
// Accepts a level only after it has been held for a set number of cycles.
`timescale 1ns/1ns
module hold_filter #(
    parameter int HOLD = 3
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic level_in,
    output logic      accept_pulse
);
    logic [7:0] count_reg;
    logic       seen_reg;
    wire        full = (count_reg >= 8'(HOLD - 1));

    // Counts consecutive high cycles and pulses once per held assertion.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg    <= 8'h00;
            seen_reg     <= 1'b0;
            accept_pulse <= 1'b0;
        end else begin
            accept_pulse <= level_in && full && !seen_reg;
            seen_reg     <= level_in && (seen_reg || full);
            if (!level_in) begin
                count_reg <= 8'h00;
            end else if (!full) begin
                count_reg <= count_reg + 8'h01;
            end
        end
    end
endmodule : hold_filter

// file: hw/staging_reg.sv
// Staging register written by fabric logic on the user clock.
`timescale 1ns/1ns
module staging_reg #(
    parameter int W = upgrade_pkg::CTRL_W
) (
    input  wire logic         upgrade_user_clock,
    input  wire logic         reset_n,
    input  wire logic         write_allow,
    input  wire logic         write_en,
    input  wire logic [W-1:0] write_data,
    output logic      [W-1:0] stage_q
);
    import upgrade_pkg::*;

    // Only a factory image may change the staging contents.
    always_ff @(posedge upgrade_user_clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= CTRL_RESET;
        end else if (write_en && write_allow) begin
            stage_q <= write_data;
        end
    end
endmodule : staging_reg

// file: verification/fabric_partner.sv
// Fabric-side model that drives the reconfiguration and reload strobes.
`timescale 1ns/1ns
module fabric_partner (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic go_req,
    input  wire logic go_reload,
    output logic      fabric_reconfig_request_n,
    output logic      watchdog_reload_n
);
    import upgrade_pkg::*;
    logic [3:0] req_cnt_reg;
    logic [3:0] rld_cnt_reg;
    // Each strobe lasts twice the minimum hold so the sequencer sees it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_cnt_reg <= 4'h0;
            rld_cnt_reg <= 4'h0;
        end else begin
            req_cnt_reg <= go_req ? 4'(2 * HOLD_CYC) :
                req_cnt_reg - 4'(req_cnt_reg != 4'h0);
            rld_cnt_reg <= go_reload ? 4'(2 * HOLD_CYC) :
                rld_cnt_reg - 4'(rld_cnt_reg != 4'h0);
        end
    end
    // The request is active high, the reload active low.
    assign fabric_reconfig_request_n = (req_cnt_reg != 4'h0);
    assign watchdog_reload_n = (rld_cnt_reg == 4'h0);
endmodule : fabric_partner

// file: verification/upgrade_assertions.sv
// Port checks for the remote upgrade sequencer.
`timescale 1ns/1ns
module upgrade_assertions (
    input wire logic                           clk,
    input wire logic                           reset_n,
    input wire logic                           wr_en,
    input wire logic                           rd_en,
    input wire logic [1:0]                     addr,
    input wire logic [upgrade_pkg::CTRL_W-1:0] rdata,
    input wire logic                           fabric_reconfig_request_n,
    input wire logic                           config_error_pin_n,
    input wire logic                           crc_error,
    input wire logic                           ext_config_reset_n,
    input wire logic                           app_mode,
    input wire logic [upgrade_pkg::PAGE_W-1:0] image_page_address,
    input wire logic                           reconfig_start,
    input wire logic                           watchdog_timeout
);
    import upgrade_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Read data, trigger handling and watchdog fallback.
    rd_idle_a: assert property (!$past(rd_en) |-> rdata == '0)
        else $error("read data outside its slot");
    app_start_a: assert property ($rose(app_mode) |-> reconfig_start)
        else $error("app mode without start");
    app_req_a: assert property (
        $rose(app_mode) |-> $past(fabric_reconfig_request_n, 1))
        else $error("app mode without request");
    crc_clear_a: assert property ($rose(crc_error) |->
        ##[1:2] (!app_mode && image_page_address == '0))
        else $error("crc did not clear control");
    pin_clear_a: assert property ($fell(config_error_pin_n) |->
        ##[1:3] (!app_mode && image_page_address == '0))
        else $error("pin error did not clear control");
    ext_clear_a: assert property ($fell(ext_config_reset_n) |->
        ##[1:2] (!app_mode && image_page_address == '0))
        else $error("reset did not clear control");
    wd_app_only_a: assert property (watchdog_timeout |-> $past(app_mode))
        else $error("timeout outside app mode");
    wd_fallback_a: assert property (watchdog_timeout |->
        ##[0:1] (!app_mode && image_page_address == '0))
        else $error("timeout kept app page");
    page_hold_a: assert property (
        wr_en ##1 (!reconfig_start && !watchdog_timeout)
        |-> $stable(image_page_address))
        else $error("write reached live control");
    cov_app_c: cover property ($rose(app_mode));
    cov_crc_c: cover property ($rose(crc_error) && app_mode);
    cov_cnt_c: cover property ($past(rd_en) && $past(addr) == 2'h3);
    cov_wd_c: cover property (watchdog_timeout);
endmodule : upgrade_assertions
bind remote_upgrade_sequencer_watchdog upgrade_assertions chk_u (
    .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .rdata(rdata), .crc_error(crc_error),
    .fabric_reconfig_request_n(fabric_reconfig_request_n),
    .config_error_pin_n(config_error_pin_n),
    .ext_config_reset_n(ext_config_reset_n), .app_mode(app_mode),
    .image_page_address(image_page_address),
    .reconfig_start(reconfig_start), .watchdog_timeout(watchdog_timeout));

// file: verification/tb.sv
// Self-checking bench for the remote upgrade sequencer.
`timescale 1ns/1ns
module tb;
    import upgrade_pkg::*;
    localparam int CFG = 4;
    localparam logic [CTRL_W-1:0] IMG = {12'h001, 1'b1, 24'h00abcd, 1'b1};
    localparam logic [CTRL_W-1:0] NOWD = {12'h001, 1'b0, 24'h000123, 1'b1};
    localparam logic [CTRL_W-1:0] FAC = {12'h001, 1'b1, 24'h000077, 1'b0};
    localparam logic [CTRL_W-1:0] WD0 = {12'h000, 1'b1, 24'h000456, 1'b1};
    logic              clk, reset_n, wr_en, rd_en, req_n, rld_n;
    logic              pin_n, crc, ext_n, app, start, tmo, go_req, go_rld;
    logic [1:0]        addr;
    logic [CTRL_W-1:0] wdata, rdata, got, c1;
    logic [PAGE_W-1:0] page;
    logic [4:0]        cause [0:4] = '{5'h04, 5'h00, 5'h01, 5'h02, 5'h08};
    int                failures, n_compared, k;
    remote_upgrade_sequencer_watchdog #(.CFG_CYC(CFG)) dut_u (.clk(clk),
        .reset_n(reset_n), .upgrade_user_clock(clk), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .fabric_reconfig_request_n(req_n), .watchdog_reload_n(rld_n),
        .config_error_pin_n(pin_n), .crc_error(crc),
        .ext_config_reset_n(ext_n), .app_mode(app),
        .image_page_address(page), .reconfig_start(start),
        .watchdog_timeout(tmo));
    fabric_partner far_u (.clk(clk), .reset_n(reset_n), .go_req(go_req),
        .go_reload(go_rld), .fabric_reconfig_request_n(req_n),
        .watchdog_reload_n(rld_n));
    // The oscillator clock toggles every half period.
    always #50 clk = ~clk;
    // Bus access, strobe and comparison helpers.
    task automatic wr(input logic [1:0] a, input logic [CTRL_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [CTRL_W-1:0] q);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        q = rdata;
        @(posedge clk);
    endtask : rd
    task automatic chk(input logic [CTRL_W-1:0] e, input logic [CTRL_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic hit(input int s, input int n);
        go_req <= (s == 0);
        go_rld <= (s == 1);
        crc <= (s == 2);
        pin_n <= (s != 3);
        ext_n <= (s != 4);
        repeat (n) @(posedge clk);
        hit_clear();
    endtask : hit
    task automatic hit_clear();
        go_req <= 1'b0;
        go_rld <= 1'b0;
        crc <= 1'b0;
        pin_n <= 1'b1;
        ext_n <= 1'b1;
    endtask : hit_clear
    task automatic launch(input logic [CTRL_W-1:0] d);
        int i;
        wr(ADDR_STAGE, d);
        hit(0, 1);
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (start !== 1'b1 && i < 20);
        if (i >= 20) begin
            failures++;
            final_report();
        end
        @(posedge clk);
    endtask : launch
    task automatic final_report();
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // Main sequence: triggers, error fallbacks, then the watchdog.
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {wr_en, rd_en, addr, wdata} = '0;
        {go_req, go_rld, crc, pin_n, ext_n} = 5'h03;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        wr(ADDR_STATUS, '1);
        rd(ADDR_STATUS, got);
        chk('0, got);
        for (k = 2; k <= 4; k++) begin
            wr(ADDR_STAGE, IMG);
            rd(ADDR_STAGE, got);
            chk(IMG, got);
            launch(IMG);
            chk(38'({app, page}), {13'h0001, 24'h00abcd});
            rd(ADDR_READ, got);
            chk(IMG, got);
            rd(ADDR_STATUS, got);
            chk(38'(cause[0]), got);
            wr(ADDR_STAGE, '0);
            hit(k, 3);
            repeat (3) @(posedge clk);
            chk(38'({app, page}), '0);
            rd(ADDR_STATUS, got);
            chk(38'(cause[k]), got);
            rd(ADDR_STAGE, got);
            chk(IMG, got);
        end
        launch(FAC);
        rd(ADDR_WDCNT, c1);
        repeat (5) @(posedge clk);
        rd(ADDR_WDCNT, got);
        chk(c1, got);
        chk(38'h20000, c1);
        launch(IMG);
        repeat (CFG + 30) @(posedge clk);
        rd(ADDR_WDCNT, c1);
        rd(ADDR_WDCNT, got);
        chk(c1 - 38'h2, got);
        chk(38'(c1 < 38'h20000 && c1 > 38'h1ff00), 38'h1);
        hit(1, 1);
        repeat (8) @(posedge clk);
        rd(ADDR_WDCNT, got);
        chk(38'(got > c1), 38'h1);
        hit(4, 3);
        repeat (3) @(posedge clk);
        launch(NOWD);
        repeat (CFG + 4) @(posedge clk);
        rd(ADDR_WDCNT, c1);
        repeat (5) @(posedge clk);
        rd(ADDR_WDCNT, got);
        chk(c1, got);
        hit(0, 1);
        repeat (10) @(posedge clk);
        rd(ADDR_STATUS, got);
        chk(38'(cause[0]), got);
        chk(38'(page), 38'h123);
        // A zero timeout runs out at once in user mode.
        hit(4, 3);
        repeat (3) @(posedge clk);
        launch(WD0);
        k = 0;
        while (tmo !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk(38'(tmo), 38'h1);
        repeat (2) @(posedge clk);
        chk(38'({app, page}), '0);
        rd(ADDR_STATUS, got);
        chk(38'h10, got);
        final_report();
    end
endmodule : tb
